// >>> rtl/piob_pkg.sv
// Behaviour
// - direction bit one makes pin input; zero enables driver from latch.
// - every port pin returns to input direction on any reset.
// - latch register reads stored latch; writes update the latch.
// - pin-level register reads sampled pins; writes go into the latch.
// - bits not valid on this device read zero in latch, direction, pin-level.
// - enabled, actively driving peripheral disables port driver; pin still readable.
// - enabled but not driving peripheral lets port logic drive the pin.
// - data and enable pass selector pair; peripheral wins over port.
// - pin whose other function is input only acts as dedicated port pin.
// - pins selected as analog inputs read low in pin-level register.
// - unimplemented bits read zero in direction, latch and pin-level registers.
package piob_pkg;
	// ****************************************
	// sizes
	// ****************************************
	localparam int NUM_PORTS = 5;
	localparam int PORT_W = 16;
	localparam int ADDR_W = 16;
	localparam int IDX_W = 14;

	// ****************************************
	// register indexes (byte address is four times the index)
	// ****************************************
	localparam logic [13:0] PORT_B_DIRECTION_IDX = 14'h02c6;
	localparam logic [13:0] PORT_B_PIN_LEVEL_IDX = 14'h02c8;
	localparam logic [13:0] PORT_B_OUTPUT_LATCH_IDX = 14'h02ca;
	localparam logic [13:0] PORT_C_DIRECTION_IDX = 14'h02cc;
	localparam logic [13:0] PORT_C_PIN_LEVEL_IDX = 14'h02ce;
	localparam logic [13:0] PORT_C_OUTPUT_LATCH_IDX = 14'h02d0;
	localparam logic [13:0] PORT_D_DIRECTION_IDX = 14'h02d2;
	localparam logic [13:0] PORT_D_PIN_LEVEL_IDX = 14'h02d4;
	localparam logic [13:0] PORT_D_OUTPUT_LATCH_IDX = 14'h02d6;
	localparam logic [13:0] PORT_E_DIRECTION_IDX = 14'h02d8;
	localparam logic [13:0] PORT_E_PIN_LEVEL_IDX = 14'h02da;
	localparam logic [13:0] PORT_E_OUTPUT_LATCH_IDX = 14'h02dc;
	localparam logic [13:0] PORT_F_DIRECTION_IDX = 14'h02de;
	localparam logic [13:0] PORT_F_PIN_LEVEL_IDX = 14'h02e0;
	localparam logic [13:0] PORT_F_OUTPUT_LATCH_IDX = 14'h02e2;
	localparam logic [13:0] ANALOG_PIN_SELECT_IDX = 14'h0300;

	localparam logic [4:0][13:0] DIRECTION_IDX = {PORT_F_DIRECTION_IDX, PORT_E_DIRECTION_IDX,
		PORT_D_DIRECTION_IDX, PORT_C_DIRECTION_IDX, PORT_B_DIRECTION_IDX};
	localparam logic [4:0][13:0] PIN_LEVEL_IDX = {PORT_F_PIN_LEVEL_IDX, PORT_E_PIN_LEVEL_IDX,
		PORT_D_PIN_LEVEL_IDX, PORT_C_PIN_LEVEL_IDX, PORT_B_PIN_LEVEL_IDX};
	localparam logic [4:0][13:0] OUTPUT_LATCH_IDX = {PORT_F_OUTPUT_LATCH_IDX, PORT_E_OUTPUT_LATCH_IDX,
		PORT_D_OUTPUT_LATCH_IDX, PORT_C_OUTPUT_LATCH_IDX, PORT_B_OUTPUT_LATCH_IDX};

	// ****************************************
	// reset values; direction reset equals the set of valid pins
	// ****************************************
	localparam logic [15:0] PORT_B_DIRECTION_RST = 16'h01ff;
	localparam logic [15:0] PORT_C_DIRECTION_RST = 16'he000;
	localparam logic [15:0] PORT_D_DIRECTION_RST = 16'h000f;
	localparam logic [15:0] PORT_E_DIRECTION_RST = 16'h013f;
	localparam logic [15:0] PORT_F_DIRECTION_RST = 16'h007f;
	localparam logic [4:0][15:0] VALID_MASK_DEF = {PORT_F_DIRECTION_RST, PORT_E_DIRECTION_RST,
		PORT_D_DIRECTION_RST, PORT_C_DIRECTION_RST, PORT_B_DIRECTION_RST};
	localparam logic [15:0] OUTPUT_LATCH_RST = 16'h0000;
	localparam logic [15:0] ANALOG_PIN_SELECT_RST = 16'h0000;
	localparam int ANALOG_PORT = 0;

	// ****************************************
	// bus encodings
	// ****************************************
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum {KIND_NONE, KIND_DIR, KIND_PIN, KIND_LAT, KIND_ANALOG} piob_kind_t;
	typedef enum {BUS_IDLE, BUS_RD_WAIT} piob_bus_state_t;
endpackage : piob_pkg

// >>> rtl/piob_pad_if.sv
`timescale 1ns/1ns
`default_nettype none
interface piob_pad_if #(
	parameter int W = 16
);
	logic [W-1:0] latch;
	logic [W-1:0] direction;
	logic [W-1:0] valid;
	logic [W-1:0] periph_en;
	logic [W-1:0] periph_drive;
	logic [W-1:0] periph_out;
	logic [W-1:0] pad_out;
	logic [W-1:0] pad_oe;

	modport port_side (
		output latch,
		output direction,
		output valid,
		output periph_en,
		output periph_drive,
		output periph_out,
		input pad_out,
		input pad_oe
	);
	modport mux_side (
		input latch,
		input direction,
		input valid,
		input periph_en,
		input periph_drive,
		input periph_out,
		output pad_out,
		output pad_oe
	);
endinterface : piob_pad_if
`default_nettype wire

// >>> rtl/piob_sync.sv
`timescale 1ns/1ns
`default_nettype none
module piob_sync #(
	parameter int W = 80
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// first stage is read only by the second
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
		end
	end

	assign sync_out = sync_ff;
endmodule : piob_sync
`default_nettype wire

// >>> rtl/piob_pad_mux.sv
`timescale 1ns/1ns
`default_nettype none
module piob_pad_mux (
	input wire logic hclk,
	input wire logic hresetn,
	piob_pad_if.mux_side pad
);
	logic [$bits(pad.latch)-1:0] owner;

	// peripheral owns the pad only while enabled and driving
	assign owner = pad.periph_en & pad.periph_drive;

	// registered so pad pins come straight from flops; costs one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pad.pad_out <= '0;
			pad.pad_oe <= '0;
		end else begin
			pad.pad_out <= pad.valid & ((owner & pad.periph_out) | (~owner & pad.latch));
			pad.pad_oe <= pad.valid & (owner | ~pad.direction);
		end
	end
endmodule : piob_pad_mux
`default_nettype wire

// >>> rtl/piob_top.sv
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module piob_top #(
	parameter logic [4:0][15:0] VALID_MASK = piob_pkg::VALID_MASK_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [15:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [4:0][15:0] pad_in,
	output logic [4:0][15:0] pad_out,
	output logic [4:0][15:0] pad_oe,
	input wire logic [4:0][15:0] periph_en,
	input wire logic [4:0][15:0] periph_drive,
	input wire logic [4:0][15:0] periph_out
);
	// ****************************************
	// state
	// ****************************************
	logic [4:0][15:0] dir_ff;
	logic [4:0][15:0] lat_ff;
	logic [15:0] analog_ff;
	logic [4:0][15:0] pin_sync;
	logic [4:0][15:0] pin_level;
	piob_pkg::piob_bus_state_t state_ff;
	logic wr_pend_ff;
	logic [13:0] idx_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic hresp_ff;
	logic take;
	logic [13:0] addr_idx;
	piob_pkg::piob_kind_t kind;
	logic [2:0] port_sel;
	logic [15:0] rd_word;

	assign take = hsel & hready & (htrans == piob_pkg::HTRANS_NONSEQ);
	assign addr_idx = haddr[15:2];

	// ****************************************
	// pin sampling
	// ****************************************
	piob_sync #(
		.W(80)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.async_in(pad_in),
		.sync_out(pin_sync)
	);

	always_comb begin
		for (int p = 0; p < piob_pkg::NUM_PORTS; p++) begin
			pin_level[p] = pin_sync[p] & VALID_MASK[p];
		end
		pin_level[piob_pkg::ANALOG_PORT] = pin_level[piob_pkg::ANALOG_PORT] & ~analog_ff;
	end

	// ****************************************
	// decode of the stored data-phase index
	// ****************************************
	always_comb begin
		kind = piob_pkg::KIND_NONE;
		port_sel = 3'h0;
		if (idx_ff == piob_pkg::ANALOG_PIN_SELECT_IDX) begin
			kind = piob_pkg::KIND_ANALOG;
		end
		for (int p = 0; p < piob_pkg::NUM_PORTS; p++) begin
			if (idx_ff == piob_pkg::DIRECTION_IDX[p]) begin
				kind = piob_pkg::KIND_DIR;
				port_sel = 3'(p);
			end
			if (idx_ff == piob_pkg::PIN_LEVEL_IDX[p]) begin
				kind = piob_pkg::KIND_PIN;
				port_sel = 3'(p);
			end
			if (idx_ff == piob_pkg::OUTPUT_LATCH_IDX[p]) begin
				kind = piob_pkg::KIND_LAT;
				port_sel = 3'(p);
			end
		end
	end

	always_comb begin
		case (kind)
			piob_pkg::KIND_DIR: rd_word = dir_ff[port_sel];
			piob_pkg::KIND_PIN: rd_word = pin_level[port_sel];
			piob_pkg::KIND_LAT: rd_word = lat_ff[port_sel];
			piob_pkg::KIND_ANALOG: rd_word = analog_ff;
			default: rd_word = 16'h0000;
		endcase
	end

	// ****************************************
	// bus slave: writes zero wait, reads one wait state
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= piob_pkg::BUS_IDLE;
			wr_pend_ff <= 1'b0;
			idx_ff <= 14'h0000;
			hreadyout_ff <= 1'b1;
		end else begin
			case (state_ff)
				piob_pkg::BUS_IDLE: begin
					wr_pend_ff <= take & hwrite;
					if (take) begin
						idx_ff <= addr_idx;
					end
					if (take && !hwrite) begin
						state_ff <= piob_pkg::BUS_RD_WAIT;
						hreadyout_ff <= 1'b0;
					end
				end
				piob_pkg::BUS_RD_WAIT: begin
					// wait state: rd_word for the stored idx_ff is registered into hrdata_ff here
					state_ff <= piob_pkg::BUS_IDLE;
					hreadyout_ff <= 1'b1;
					wr_pend_ff <= 1'b0;
				end
				default: begin
					state_ff <= piob_pkg::BUS_IDLE;
					hreadyout_ff <= 1'b1;
					wr_pend_ff <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_ff <= 32'h00000000;
		end else if (state_ff == piob_pkg::BUS_RD_WAIT) begin
			hrdata_ff <= {16'h0000, rd_word};
		end
	end

	// only OKAY is ever answered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hresp_ff <= piob_pkg::HRESP_OKAY;
		end else begin
			hresp_ff <= piob_pkg::HRESP_OKAY;
		end
	end

	// ****************************************
	// port registers
	// ****************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_ff <= VALID_MASK;
		end else if (wr_pend_ff && kind == piob_pkg::KIND_DIR) begin
			dir_ff[port_sel] <= hwdata[15:0] & VALID_MASK[port_sel];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_ff <= {piob_pkg::NUM_PORTS{piob_pkg::OUTPUT_LATCH_RST}};
		end else if (wr_pend_ff && (kind == piob_pkg::KIND_LAT || kind == piob_pkg::KIND_PIN)) begin
			lat_ff[port_sel] <= hwdata[15:0] & VALID_MASK[port_sel];
		end
	end

	// no guard against analog pins left as outputs; software must set direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			analog_ff <= piob_pkg::ANALOG_PIN_SELECT_RST;
		end else if (wr_pend_ff && kind == piob_pkg::KIND_ANALOG) begin
			analog_ff <= hwdata[15:0] & VALID_MASK[piob_pkg::ANALOG_PORT];
		end
	end

	// ****************************************
	// pad selectors, one per port
	// ****************************************
	for (genvar g = 0; g < piob_pkg::NUM_PORTS; g++) begin : g_port
		piob_pad_if #(.W(16)) u_if ();
		assign u_if.latch = lat_ff[g];
		assign u_if.direction = dir_ff[g];
		assign u_if.valid = VALID_MASK[g];
		assign u_if.periph_en = periph_en[g];
		assign u_if.periph_drive = periph_drive[g];
		assign u_if.periph_out = periph_out[g];
		assign pad_out[g] = u_if.pad_out;
		assign pad_oe[g] = u_if.pad_oe;
		piob_pad_mux u_mux (
			.hclk(hclk),
			.hresetn(hresetn),
			.pad(u_if.mux_side)
		);
	end

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = hresp_ff;
endmodule : piob_top
`default_nettype wire

// >>> verification/piob_asserts.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bus and pad checks
// ****************************************
module piob_asserts #(
	parameter logic [4:0][15:0] VALID_MASK = piob_pkg::VALID_MASK_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [4:0][15:0] pad_out,
	input wire logic [4:0][15:0] pad_oe,
	input wire logic [4:0][15:0] periph_en,
	input wire logic [4:0][15:0] periph_drive,
	input wire logic [4:0][15:0] periph_out
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [4:0][15:0] own;
	assign own = periph_en & periph_drive;
	sequence s_req(w);
		hsel && hready && htrans == piob_pkg::HTRANS_NONSEQ && hwrite == w;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait; s_req(1'b0) |=> s_one_wait; endproperty
	property p_wr_nowait; s_req(1'b1) |=> hreadyout; endproperty
	property p_okay; hresp == piob_pkg::HRESP_OKAY; endproperty
	property p_upper; hreadyout |-> hrdata[31:16] == 16'h0; endproperty
	property p_hold; hreadyout && $past(hreadyout) |-> $stable(hrdata); endproperty
	property p_invalid; ((pad_oe | pad_out) & ~VALID_MASK) == 80'h0; endproperty
	// past guard: the pad registers do not update while reset is held
	property p_owner_oe; $past(hresetn) |-> (pad_oe & $past(own) & VALID_MASK) == ($past(own) & VALID_MASK); endproperty
	property p_owner_out; $past(hresetn) |-> ((pad_out ^ $past(periph_out)) & $past(own) & VALID_MASK) == 80'h0; endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	a_wr_nowait: assert property (p_wr_nowait) else $error("write was stalled");
	a_okay: assert property (p_okay) else $error("response not okay");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_hold: assert property (p_hold) else $error("read data moved");
	a_invalid: assert property (p_invalid) else $error("invalid pin driven");
	a_owner_oe: assert property (p_owner_oe) else $error("peripheral lost enable");
	a_owner_out: assert property (p_owner_out) else $error("peripheral lost data");
endmodule : piob_asserts
`default_nettype wire

// >>> verification/piob_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// pads: driven level wins, else outside level
// ****************************************
module piob_pad_model (
	input wire logic [4:0][15:0] pad_out,
	input wire logic [4:0][15:0] pad_oe,
	input wire logic [4:0][15:0] ext_level,
	output logic [4:0][15:0] pad_in
);
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule : piob_pad_model
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// bench
// ****************************************
module tb_top;
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic [15:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [4:0][15:0] pad_in, pad_out, pad_oe, periph_en, periph_drive, periph_out, ext_level;
	int err_total, tests_run;
	piob_top piob_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
		.periph_en(periph_en), .periph_drive(periph_drive), .periph_out(periph_out));
	piob_pad_model piob_pad_model_inst (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));
	initial begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	function automatic logic [13:0] ix(input int k, input int p);
		return k == 0 ? piob_pkg::DIRECTION_IDX[p] : k == 1 ? piob_pkg::PIN_LEVEL_IDX[p] : piob_pkg::OUTPUT_LATCH_IDX[p];
	endfunction : ix
	function automatic logic [31:0] m(input int p);
		return {16'h0, piob_pkg::VALID_MASK_DEF[p]};
	endfunction : m
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// bus master; waits on hreadyout with no assumed latency
	task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
		htrans <= piob_pkg::HTRANS_NONSEQ;
		haddr <= {idx, 2'h0};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask : bus
	task automatic wr(input int k, input int p, input logic [31:0] d);
		bus(1'b1, ix(k, p), d);
	endtask : wr
	task automatic rdc(input int k, input int p, input logic [31:0] e);
		bus(1'b0, ix(k, p), 32'h0);
		chk(q, e);
	endtask : rdc
	task automatic t_reset;
		for (int p = 0; p < 5; p++) begin
			rdc(0, p, m(p));
			rdc(2, p, 32'h0);
			rdc(1, p, m(p));
		end
		chk({31'h0, |pad_oe}, 32'h0);
	endtask : t_reset
	task automatic t_latch;
		for (int p = 0; p < 5; p++) begin
			wr(2, p, 32'hffff_ffff);
			rdc(2, p, m(p));
			wr(1, p, 32'h0000_5555);
			rdc(2, p, m(p) & 32'h5555);
			wr(0, p, 32'hffff_ffff);
			rdc(0, p, m(p));
		end
	endtask : t_latch
	task automatic t_out;
		wr(2, 2, 32'h5);
		wr(0, 2, 32'h0);
		repeat (3) @(posedge hclk); // settle before reading back
		chk({16'h0, pad_oe[2]}, 32'h000f);
		chk({16'h0, pad_out[2]}, 32'h0005);
		rdc(1, 2, 32'h5);
		// two-flop sampling: the first read still shows the old level
		ext_level[3] <= 16'h0000;
		rdc(1, 3, m(3));
		rdc(1, 3, 32'h0);
	endtask : t_out
	task automatic t_periph;
		wr(2, 1, 32'h0);
		wr(0, 1, 32'h0);
		periph_en[1] <= 16'he000;
		periph_drive[1] <= 16'h2000;
		periph_out[1] <= 16'h2000;
		repeat (3) @(posedge hclk);
		chk({16'h0, pad_out[1]}, 32'h2000);
		rdc(1, 1, 32'h2000);
		wr(2, 1, 32'hc000);
		repeat (2) @(posedge hclk);
		chk({16'h0, pad_out[1]}, 32'he000);
		wr(0, 1, 32'he000);
		repeat (2) @(posedge hclk);
		chk({16'h0, pad_oe[1]}, 32'h2000);
		periph_en[1] <= 16'h0;
	endtask : t_periph
	task automatic t_misc;
		// analog pins of port B are still inputs here
		bus(1'b1, piob_pkg::ANALOG_PIN_SELECT_IDX, 32'h000f);
		rdc(1, 0, 32'h01f0);
		bus(1'b0, piob_pkg::ANALOG_PIN_SELECT_IDX, 32'h0);
		chk(q, 32'h000f);
		bus(1'b1, 14'h0001, 32'h1234);
		bus(1'b0, 14'h0001, 32'h0);
		chk(q, 32'h0);
		// a deselected write must leave the latch alone
		hsel <= 1'b0;
		wr(2, 4, 32'h0000_ffff);
		hsel <= 1'b1;
		rdc(2, 4, m(4) & 32'h5555);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		chk({31'h0, |pad_oe}, 32'h0);
		hresetn <= 1'b1;
		rdc(0, 2, m(2));
	endtask : t_misc
	task automatic stop_test;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : stop_test
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 16'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		periph_en = '0;
		periph_drive = '0;
		periph_out = '0;
		ext_level = '1;
		err_total = 0;
		tests_run = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_latch;
		t_out;
		t_periph;
		t_misc;
		stop_test;
	end
	initial begin
		repeat (20000) @(posedge hclk);
		err_total++;
		stop_test;
	end
endmodule : tb_top
bind piob_top piob_asserts #(.VALID_MASK(VALID_MASK)) piob_asserts_inst (.hclk(hclk), .hresetn(hresetn),
	.hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .pad_out(pad_out), .pad_oe(pad_oe), .periph_en(periph_en), .periph_drive(periph_drive),
	.periph_out(periph_out));
`default_nettype wire
